//--- verilog/srfc_pkg.sv
`default_nettype none
package srfc_pkg;

  // Register word offsets (byte addresses)
  localparam logic [11:0] SRFC_ADDR_FREE_RUN   = 12'h09C;
  localparam logic [11:0] SRFC_ADDR_SOFT_RESET_CONTROL  = 12'h1F8;

  // Reset control field positions
  localparam int SRFC_BIT_CHIP_RST   = 0;
  localparam int SRFC_BIT_PORT1_RST  = 1;
  localparam int SRFC_BIT_PORT2_RST  = 2;
  localparam int SRFC_BIT_EMU_RST    = 3;
  localparam int SRFC_CTL_BITS       = 4;

  // Reset values
  localparam logic [31:0] SRFC_COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] SRFC_READ_ZERO   = 32'h0000_0000;
  localparam logic [15:0] SRFC_HALF_ZERO   = 16'h0000;

  // Clock and timing figures
  localparam int SRFC_SYS_CLK_MHZ     = 100;
  localparam int SRFC_COUNT_CLK_MHZ   = 25;
  localparam int SRFC_CLK_PERIOD_NS   = 10;
  localparam int SRFC_COUNT_DIV       = SRFC_SYS_CLK_MHZ / SRFC_COUNT_CLK_MHZ;
  localparam int SRFC_CLEAR_MAX_NS    = 160;
  localparam int SRFC_CLEAR_MAX_CYC   = SRFC_CLEAR_MAX_NS / SRFC_CLK_PERIOD_NS;
  localparam int SRFC_PORT_HOLD_NS    = 102000;
  localparam int SRFC_PORT_HOLD_CYC   = (SRFC_PORT_HOLD_NS + SRFC_CLK_PERIOD_NS - 1) / SRFC_CLK_PERIOD_NS;
  localparam int SRFC_EMU_HOLD_CYC    = 4;
  localparam int SRFC_CHIP_HOLD_CYC   = 8;

  // Hold sequencer states
  typedef enum logic [1:0] {
    SRFC_HOLD_IDLE = 2'b01,
    SRFC_HOLD_BUSY = 2'b10
  } srfc_hold_state_t;

endpackage
`default_nettype wire

//--- verilog/srfc_reset_hold.sv
`timescale 1ns/1ps
`default_nettype none
module srfc_reset_hold #(
  parameter int HOLD_CYCLES = 4,
  parameter int CW          = 16
) (
  input  wire logic sys_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic start_in,
  output logic      busy_out,
  output logic      release_out
);

  srfc_pkg::srfc_hold_state_t state_q;
  srfc_pkg::srfc_hold_state_t state_d;
  logic [CW-1:0]              cnt_q;
  logic [CW-1:0]              cnt_d;
  logic                       done;

  localparam logic [CW-1:0] LAST = CW'(HOLD_CYCLES - 1);
  localparam logic [CW-1:0] ZERO = '0;

  assign done = (state_q == srfc_pkg::SRFC_HOLD_BUSY) && (cnt_q == LAST);

  // Next state: start only from idle, release after the hold count
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      srfc_pkg::SRFC_HOLD_IDLE: begin
        cnt_d = ZERO;
        if (start_in) begin
          state_d = srfc_pkg::SRFC_HOLD_BUSY;
        end
      end
      srfc_pkg::SRFC_HOLD_BUSY: begin
        if (done) begin
          state_d = srfc_pkg::SRFC_HOLD_IDLE;
          cnt_d   = ZERO;
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end
      default: begin
        state_d = srfc_pkg::SRFC_HOLD_IDLE;
        cnt_d   = ZERO;
      end
    endcase
  end

  // State and counter registers
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state_q <= srfc_pkg::SRFC_HOLD_IDLE;
      cnt_q   <= ZERO;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign busy_out    = (state_q == srfc_pkg::SRFC_HOLD_BUSY);
  assign release_out = done;

endmodule
`default_nettype wire

//--- verilog/srfc_soft_reset.sv
`timescale 1ns/1ps
`default_nettype none
module srfc_soft_reset #(
  parameter int PORT_HOLD_CYCLES = srfc_pkg::SRFC_PORT_HOLD_CYC,
  parameter int EMU_HOLD_CYCLES  = srfc_pkg::SRFC_EMU_HOLD_CYC,
  parameter int CHIP_HOLD_CYCLES = srfc_pkg::SRFC_CHIP_HOLD_CYC,
  parameter int COUNT_WIDTH      = 32,
  parameter int HOLD_CW          = 16
) (
  input  wire logic        sys_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        wr_en_in,
  input  wire logic [11:0] wr_addr_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic        rd_en_in,
  input  wire logic [11:0] rd_addr_in,
  input  wire logic        half_mode_in,
  input  wire logic        rd_upper_in,
  output logic [31:0]      rd_data_out,
  output logic             rd_valid_out,
  output logic             chip_reset_out,
  output logic             loader_abort_out,
  output logic             loader_reload_out,
  output logic             port1_reset_out,
  output logic             port2_reset_out,
  output logic             emu_reset_out
);

  // Address decode
  logic wr_ctl;
  logic rd_ctl;
  logic rd_cnt;
  assign wr_ctl = wr_en_in && (wr_addr_in == srfc_pkg::SRFC_ADDR_SOFT_RESET_CONTROL);
  assign rd_ctl = rd_en_in && (rd_addr_in == srfc_pkg::SRFC_ADDR_SOFT_RESET_CONTROL);
  assign rd_cnt = rd_en_in && (rd_addr_in == srfc_pkg::SRFC_ADDR_FREE_RUN);

  // Hold sequencer status
  logic chip_busy;
  logic chip_release;
  logic port1_busy;
  logic port2_busy;
  logic emu_busy;

  // Start requests: host write of one, bit idle; zero writes do nothing
  logic chip_start;
  logic port1_start;
  logic port2_start;
  logic emu_start;
  assign chip_start  = wr_ctl && wr_data_in[srfc_pkg::SRFC_BIT_CHIP_RST] && !chip_busy;
  assign port1_start = wr_ctl && wr_data_in[srfc_pkg::SRFC_BIT_PORT1_RST] && !port1_busy;
  assign port2_start = wr_ctl && wr_data_in[srfc_pkg::SRFC_BIT_PORT2_RST] && !port2_busy;
  assign emu_start   = wr_ctl && wr_data_in[srfc_pkg::SRFC_BIT_EMU_RST] && !emu_busy;

  // Whole-chip soft reset sequencer
  srfc_reset_hold #(
    .HOLD_CYCLES (CHIP_HOLD_CYCLES),
    .CW          (HOLD_CW)
  ) u_chip_hold (
    .sys_clk_in  (sys_clk_in),
    .sys_rst_in  (sys_rst_in),
    .start_in    (chip_start),
    .busy_out    (chip_busy),
    .release_out (chip_release)
  );

  // First port transceiver reset sequencer
  srfc_reset_hold #(
    .HOLD_CYCLES (PORT_HOLD_CYCLES),
    .CW          (HOLD_CW)
  ) u_port1_hold (
    .sys_clk_in  (sys_clk_in),
    .sys_rst_in  (sys_rst_in),
    .start_in    (port1_start),
    .busy_out    (port1_busy),
    .release_out ()
  );

  // Second port transceiver reset sequencer
  srfc_reset_hold #(
    .HOLD_CYCLES (PORT_HOLD_CYCLES),
    .CW          (HOLD_CW)
  ) u_port2_hold (
    .sys_clk_in  (sys_clk_in),
    .sys_rst_in  (sys_rst_in),
    .start_in    (port2_start),
    .busy_out    (port2_busy),
    .release_out ()
  );

  // Emulated transceiver reset sequencer
  srfc_reset_hold #(
    .HOLD_CYCLES (EMU_HOLD_CYCLES),
    .CW          (HOLD_CW)
  ) u_emu_hold (
    .sys_clk_in  (sys_clk_in),
    .sys_rst_in  (sys_rst_in),
    .start_in    (emu_start),
    .busy_out    (emu_busy),
    .release_out ()
  );

  // Reset outputs follow the sequencers; chip reset spares transceivers
  assign chip_reset_out   = chip_busy;
  assign loader_abort_out = chip_busy;
  assign port1_reset_out  = port1_busy;
  assign port2_reset_out  = port2_busy;
  assign emu_reset_out    = emu_busy;

  // Reload trigger in the first cycle the chip is out of reset
  logic reload_q;
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      reload_q <= 1'b0;
    end else begin
      reload_q <= chip_release;
    end
  end
  assign loader_reload_out = reload_q;

  // 25MHz enable from the 100MHz clock
  localparam int DIV_W = $clog2(srfc_pkg::SRFC_COUNT_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(srfc_pkg::SRFC_COUNT_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;
  logic [DIV_W-1:0] div_q;
  logic             tick;
  assign tick = (div_q == DIV_LAST);
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || chip_busy) begin
      div_q <= DIV_ZERO;
    end else if (tick) begin
      div_q <= DIV_ZERO;
    end else begin
      div_q <= div_q + DIV_W'(1);
    end
  end

  // Free-running counter; cleared by both resets, writes never reach it
  localparam logic [COUNT_WIDTH-1:0] CNT_ZERO = COUNT_WIDTH'(srfc_pkg::SRFC_COUNT_RESET);
  logic [COUNT_WIDTH-1:0] count_q;
  logic [COUNT_WIDTH-1:0] count_d;
  assign count_d = count_q + COUNT_WIDTH'(1);
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || chip_busy) begin
      count_q <= CNT_ZERO;
    end else if (tick) begin
      count_q <= count_d;
    end
  end

  // Read data selection; control readable at all times
  logic [31:0] ctl_word;
  logic [31:0] cnt_word;
  logic [31:0] full_word;
  logic [31:0] half_word;
  logic [31:0] rd_word;
  assign ctl_word = {28'h0000000, emu_busy, port2_busy, port1_busy, chip_busy};
  assign cnt_word = 32'(count_q);
  assign full_word = rd_ctl ? ctl_word : (rd_cnt ? cnt_word : srfc_pkg::SRFC_READ_ZERO);
  assign half_word = {srfc_pkg::SRFC_HALF_ZERO, rd_upper_in ? full_word[31:16] : full_word[15:0]};
  assign rd_word  = half_mode_in ? half_word : full_word;

  // Registered read answer
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rd_data_out  <= srfc_pkg::SRFC_READ_ZERO;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_en_in;
      if (rd_en_in) begin
        rd_data_out <= rd_word;
      end
    end
  end

  // Helper: clear bound after a chip reset, first-cycle guard
  localparam int CLR_MAX = srfc_pkg::SRFC_CLEAR_MAX_CYC;
  logic past_valid_q;
  always_ff @(posedge sys_clk_in) begin
    past_valid_q <= 1'b1;
  end

  // Helper: busy-cycle counter of first port reset
  logic [HOLD_CW-1:0] p1_len_q;
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || !port1_busy) begin
      p1_len_q <= '0;
    end else begin
      p1_len_q <= p1_len_q + HOLD_CW'(1);
    end
  end

  // Helper: busy-cycle counter of second port reset
  logic [HOLD_CW-1:0] p2_len_q;
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || !port2_busy) begin
      p2_len_q <= '0;
    end else begin
      p2_len_q <= p2_len_q + HOLD_CW'(1);
    end
  end

  a_count_step: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (tick && !chip_busy && past_valid_q) |=> (count_q == $past(count_q) + COUNT_WIDTH'(1)) || chip_busy)
    else $error("free counter did not step on the 25MHz enable");

  a_count_still: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (!tick && !chip_busy) |=> $stable(count_q) || chip_busy)
    else $error("free counter moved without the enable");

  a_count_wrap: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (tick && !chip_busy && (count_q == '1)) |=> (count_q == CNT_ZERO) || chip_busy)
    else $error("free counter did not wrap to zero");

  a_count_clear: assert property (@(posedge sys_clk_in)
    sys_rst_in |=> (count_q == CNT_ZERO))
    else $error("free counter not cleared after reset");

  a_write_no_count: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (wr_en_in && (wr_addr_in == srfc_pkg::SRFC_ADDR_FREE_RUN) && !tick && !chip_busy) |=> $stable(count_q))
    else $error("host write altered the free counter");

  a_emu_start: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    emu_start |=> emu_reset_out [*4] ##1 !emu_reset_out)
    else $error("emulated transceiver reset length wrong");

  a_port1_hold: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    $fell(port1_busy) |-> ($past(p1_len_q) == HOLD_CW'(PORT_HOLD_CYCLES - 1)))
    else $error("first port reset released early");

  a_port2_hold: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    $fell(port2_busy) |-> ($past(p2_len_q) == HOLD_CW'(PORT_HOLD_CYCLES - 1)))
    else $error("second port reset released early");

  a_write_ignored: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (port1_busy && !u_port1_hold.done) |=> port1_busy)
    else $error("set reset bit disturbed by write");

  a_chip_spares: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (chip_reset_out && !wr_ctl) |=> !$rose(port1_reset_out) && !$rose(port2_reset_out) && !$rose(emu_reset_out))
    else $error("chip reset touched transceivers");

  a_reload_after: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    $fell(chip_reset_out) |-> loader_reload_out && !$rose(port1_reset_out) && !$rose(emu_reset_out))
    else $error("no reload after chip reset");

  a_abort_during: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    chip_reset_out |-> loader_abort_out)
    else $error("loader not aborted during chip reset");

  a_ctl_readback: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (rd_ctl && !half_mode_in) |=> (rd_data_out[srfc_pkg::SRFC_BIT_CHIP_RST] == $past(chip_busy)))
    else $error("chip reset bit readback wrong");

  a_read_reserved: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (rd_ctl && !half_mode_in) |=> (rd_data_out[31:srfc_pkg::SRFC_CTL_BITS] == '0) && rd_valid_out)
    else $error("reserved control bits not zero");

  a_half_upper: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (rd_cnt && half_mode_in && rd_upper_in && !tick) |=> (rd_data_out == {16'h0000, count_q[31:16]}))
    else $error("upper half read wrong");

  a_zero_write: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (wr_ctl && (wr_data_in[3:0] == 4'h0) && !port2_busy) |=> !port2_busy)
    else $error("zero write started a reset");

  a_count_soon: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    $rose(chip_busy) |-> ##[1:CLR_MAX] (count_q == CNT_ZERO))
    else $error("free counter not cleared in time after chip reset");

  a_chip_clears: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    chip_busy |=> (count_q == CNT_ZERO))
    else $error("free counter not held at zero during chip reset");

  a_divider_restart: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    chip_busy |=> !tick)
    else $error("rate divider not restarted by chip reset");

  a_tick_spacing: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    tick |=> !tick [*3])
    else $error("counter enable came too soon");

  a_ctl_bits: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (rd_ctl && !half_mode_in) |=>
      (rd_data_out[srfc_pkg::SRFC_BIT_EMU_RST] == $past(emu_reset_out)) &&
      (rd_data_out[srfc_pkg::SRFC_BIT_PORT2_RST] == $past(port2_reset_out)) &&
      (rd_data_out[srfc_pkg::SRFC_BIT_PORT1_RST] == $past(port1_reset_out)))
    else $error("reset bits do not follow the reset lines");

  a_port1_rise: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    port1_start |=> port1_reset_out)
    else $error("first port reset did not start");

  a_port2_rise: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    port2_start |=> port2_reset_out)
    else $error("second port reset did not start");

  a_chip_length: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    chip_start |=> chip_reset_out [*8] ##1 !chip_reset_out)
    else $error("chip reset length wrong");

  a_chip_ignored: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (chip_busy && !chip_release) |=> chip_busy)
    else $error("chip reset bit cleared before release");

  a_reload_pulse: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    loader_reload_out |=> !loader_reload_out)
    else $error("reload trigger longer than one cycle");

  a_read_valid: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    rd_en_in |=> rd_valid_out)
    else $error("read not answered");

  a_valid_pulse: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    !rd_en_in |=> !rd_valid_out)
    else $error("read answer without a read");

  a_half_lower: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (rd_ctl && half_mode_in && !rd_upper_in) |=> (rd_data_out[31:srfc_pkg::SRFC_CTL_BITS] == '0) &&
      (rd_data_out[srfc_pkg::SRFC_BIT_PORT1_RST] == $past(port1_reset_out)))
    else $error("lower half read wrong");

  a_unmapped_zero: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (rd_en_in && !rd_ctl && !rd_cnt) |=> (rd_data_out == srfc_pkg::SRFC_READ_ZERO))
    else $error("unmapped read not zero");

  a_zero_emu: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (wr_ctl && !wr_data_in[srfc_pkg::SRFC_BIT_EMU_RST] && !emu_busy) |=> !emu_busy)
    else $error("zero bit started emulated reset");

endmodule
`default_nettype wire

//--- tb/srfc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module srfc_host_model (
  input  wire logic   clk_in,
  input  wire logic   busy_in,
  output logic        wr_en_out,
  output logic [11:0] wr_addr_out,
  output logic [31:0] wr_data_out,
  output logic        rd_en_out,
  output logic [11:0] rd_addr_out,
  output logic        half_out,
  output logic        upper_out,
  output logic        stall_out
);
  // Idle bus levels at time zero
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    wr_addr_out = 12'h000;
    rd_addr_out = 12'h000;
    wr_data_out = 32'h0000_0000;
    half_out = 1'b0;
    upper_out = 1'b0;
    stall_out = 1'b0;
  end

  // One write; held off while the chip is in soft reset
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    while (busy_in && n < 50) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    // Ran out of patience: flag it for the bench
    if (n >= 50)
      stall_out = 1'b1;
    @(posedge clk_in);
    wr_en_out <= 1'b1;
    wr_addr_out <= a;
    wr_data_out <= d;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    wr_addr_out <= ~a;
    wr_data_out <= ~d;
    #1;
  endtask

  // One read; answer is settled when this returns
  task automatic rd(input logic [11:0] a, input logic h, input logic u);
    @(posedge clk_in);
    rd_en_out <= 1'b1;
    rd_addr_out <= a;
    half_out <= h;
    upper_out <= u;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    rd_addr_out <= ~a;
    #1;
  endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        sys_clk_in;
  logic        sys_rst_in;
  logic        wr_en, rd_en, half, upper;
  logic [11:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data, c0;
  logic        rd_valid, chip_rst, abort, reload, p1, p2, emu;
  logic        host_stall;
  localparam int PORT_HOLD = 20;
  int          fail_count;
  int          num_checks;
  int          n;

  srfc_host_model i_host (
    .clk_in      (sys_clk_in),
    .busy_in     (chip_rst),
    .wr_en_out   (wr_en),
    .wr_addr_out (wr_addr),
    .wr_data_out (wr_data),
    .rd_en_out   (rd_en),
    .rd_addr_out (rd_addr),
    .half_out    (half),
    .upper_out   (upper),
    .stall_out   (host_stall)
  );

  srfc_soft_reset #(.PORT_HOLD_CYCLES(PORT_HOLD)) i_dut (
    .sys_clk_in        (sys_clk_in),
    .sys_rst_in        (sys_rst_in),
    .wr_en_in          (wr_en),
    .wr_addr_in        (wr_addr),
    .wr_data_in        (wr_data),
    .rd_en_in          (rd_en),
    .rd_addr_in        (rd_addr),
    .half_mode_in      (half),
    .rd_upper_in       (upper),
    .rd_data_out       (rd_data),
    .rd_valid_out      (rd_valid),
    .chip_reset_out    (chip_rst),
    .loader_abort_out  (abort),
    .loader_reload_out (reload),
    .port1_reset_out   (p1),
    .port2_reset_out   (p2),
    .emu_reset_out     (emu)
  );

  // 100 MHz clock
  always #5 sys_clk_in = ~sys_clk_in;

  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic tick();
    @(posedge sys_clk_in);
    #1;
  endtask

  // Read and compare the answer
  task automatic rd_chk(input logic [11:0] a, input logic h, input logic u, input logic [31:0] exp);
    i_host.rd(a, h, u);
    check({31'h0, rd_valid}, 32'h1);
    check(rd_data, exp);
  endtask

  // Count cycles a reset line stays high, bounded
  task automatic hold_len(input int sel, input int start, input int exp);
    n = start;
    while ((sel == 0 ? chip_rst : p1) && n < 100) begin
      n++;
      tick();
    end
    if (n >= 100) begin
      fail_count++;
      wrap_up();
    end else begin
      check(n, exp);
    end
  endtask

  // Counter rate and write protection
  task automatic t_counter();
    i_host.rd(12'h09C, 1'b0, 1'b0);
    c0 = rd_data;
    repeat (38) tick();
    i_host.wr(12'h09C, 32'hFFFF_FFFF);
    i_host.rd(12'h09C, 1'b0, 1'b0);
    check(rd_data - c0, 32'h0000_000A);
    check({31'h0, rd_data < 32'h0000_0100}, 32'h1);
    rd_chk(12'h09C, 1'b1, 1'b1, 32'h0000_0000);
    rd_chk(12'h0A0, 1'b0, 1'b0, 32'h0000_0000);
  endtask

  // Emulated transceiver reset, rewrite while busy
  task automatic t_emu();
    i_host.wr(12'h1F8, 32'h0000_0008);
    check({31'h0, emu}, 32'h1);
    i_host.wr(12'h1F8, 32'h0000_0008);
    check({31'h0, emu}, 32'h1);
    rd_chk(12'h1F8, 1'b0, 1'b0, 32'h0000_0008);
    check({31'h0, emu}, 32'h0);
    tick();
    check({31'h0, emu}, 32'h0);
    rd_chk(12'h1F8, 1'b0, 1'b0, 32'h0000_0000);
  endtask

  // Both port resets, zero writes, half reads
  task automatic t_ports();
    i_host.wr(12'h1F8, 32'hFFFF_FFF0);
    check({28'h0, p1, p2, emu, chip_rst}, 32'h0);
    i_host.wr(12'h1F8, 32'h0000_0006);
    i_host.wr(12'h1F8, 32'hFFFF_FFF0);
    rd_chk(12'h1F8, 1'b1, 1'b0, 32'h0000_0006);
    rd_chk(12'h1F8, 1'b1, 1'b1, 32'h0000_0000);
    hold_len(1, 6, PORT_HOLD);
    check({30'h0, p2, emu}, 32'h0);
    rd_chk(12'h1F8, 1'b0, 1'b0, 32'h0000_0000);
  endtask

  // Whole-chip soft reset and reload
  task automatic t_chip();
    i_host.wr(12'h1F8, 32'h0000_0001);
    check({30'h0, chip_rst, abort}, 32'h3);
    check({29'h0, p1, p2, emu}, 32'h0);
    rd_chk(12'h1F8, 1'b0, 1'b0, 32'h0000_0001);
    hold_len(0, 2, srfc_pkg::SRFC_CHIP_HOLD_CYC);
    check({31'h0, reload}, 32'h1);
    tick();
    check({31'h0, reload}, 32'h0);
    i_host.rd(12'h09C, 1'b0, 1'b0);
    check({31'h0, rd_data < 32'h0000_0004}, 32'h1);
    rd_chk(12'h1F8, 1'b0, 1'b0, 32'h0000_0000);
  endtask

  // Main sequence
  initial begin
    sys_clk_in = 1'b0;
    sys_rst_in = 1'b1;
    fail_count = 0;
    num_checks = 0;
    repeat (5) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    #1;
    rd_chk(12'h1F8, 1'b0, 1'b0, 32'h0000_0000);
    i_host.rd(12'h09C, 1'b0, 1'b0);
    check({31'h0, rd_data < 32'h0000_0004}, 32'h1);
    t_counter();
    t_emu();
    t_ports();
    t_chip();
    check({31'h0, host_stall}, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
